// >>> core/ledfs_top.sv
// LED function select: two programmable LED outputs behind an APB slave
//
// Functional notes
// - Each LED output is the OR of all events enabled in its control register.
// - First LED register resets to receive polarity plus stretching; fully writable.
// - Second LED register resets to transmit activity plus stretching; fully writable.
// - Bit 15 reads the live unstretched OR; writes to it are ignored.
// - Bits 14:8 and 6:5 read zero; software writes zero there.
// - Bit 7 set stretches each rising edge of the enabled-event OR; clear follows unstretched state.
// - Bit 4 adds transmit activity to the LED's events.
// - Bit 3 lights the LED while receive polarity is correct.
// - Bits 2, 1, 0 enable receive activity, jabber and collision events.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`include "ledfs_map.svh"

module ledfs_top
    import ledfs_pkg::*;
#(
    parameter int STRETCH_CYCLES = `LEDFS_STRETCH_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Event sources, active high levels
    input wire logic i_tx_activity,
    input wire logic i_rx_polarity_ok,
    input wire logic i_rx_activity,
    input wire logic i_jabber,
    input wire logic i_collision,
    // LED outputs, active high
    output logic o_first_led_output,
    output logic o_second_led_output
);
    // ======================================================================
    // Register decode helpers
    function automatic logic [1:0] ledfs_sel(input logic [11:0] addr);
        ledfs_sel = {addr == `LEDFS_OFF_CTRL_SECOND, addr == `LEDFS_OFF_CTRL_FIRST};
    endfunction

    function automatic logic ledfs_hit(input ledfs_ctrl_t ctrl, input ledfs_event_t ev);
        // Bit order follows the register: tx, pol, rx, jab, col
        ledfs_hit = |(ctrl[4:0] & ev);
    endfunction

    // ======================================================================
    // Control registers
    ledfs_ctrl_t ctrl_q [2];
    ledfs_ctrl_t ctrl_d [2];
    logic [31:0] rdata_q, rdata_d;
    logic ready_q, ready_d;
    logic slverr_q, slverr_d;
    logic [1:0] sel;
    logic setup;
    ledfs_event_t events;
    logic [1:0] live;
    logic [1:0] live_q;
    logic [1:0] live_d;
    logic [1:0] led_out;

    assign sel = ledfs_sel(i_paddr);
    assign setup = i_psel && !i_penable;
    assign events = {i_tx_activity, i_rx_polarity_ok, i_rx_activity, i_jabber, i_collision};

    always_comb begin
        ctrl_d[0] = ctrl_q[0];
        ctrl_d[1] = ctrl_q[1];
        rdata_d = rdata_q;
        ready_d = 1'b0;
        slverr_d = 1'b0;
        // No wait states: answer registered in the setup cycle, ready in the first access cycle
        if (setup) begin
            ready_d = 1'b1;
            slverr_d = ~|sel;
            rdata_d = 32'h0000_0000;
            if (!i_pwrite) begin
                for (int k = 0; k < 2; k++) begin
                    if (sel[k]) begin
                        // Reserved bits come back zero
                        rdata_d[`LEDFS_BIT_UNSTRETCHED] = live[k];
                        rdata_d[7:0] = ctrl_q[k] & `LEDFS_WRITABLE_MASK;
                    end
                end
            end
        end
        // Write takes effect at the completing edge; bit 15 and reserved dropped
        if (i_psel && i_penable && ready_q && i_pwrite && i_pstrb[0]) begin
            for (int k = 0; k < 2; k++) begin
                if (sel[k]) begin
                    ctrl_d[k] = i_pwdata[7:0] & `LEDFS_WRITABLE_MASK;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ctrl_q[0] <= `LEDFS_RST_CTRL_FIRST;
            ctrl_q[1] <= `LEDFS_RST_CTRL_SECOND;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            slverr_q <= 1'b0;
        end else begin
            ctrl_q[0] <= ctrl_d[0];
            ctrl_q[1] <= ctrl_d[1];
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            slverr_q <= slverr_d;
        end
    end

    assign o_prdata = rdata_q;
    assign o_pready = ready_q;
    assign o_pslverr = slverr_q;

    // ======================================================================
    // Per-output event OR and stretching
    always_comb begin
        live_d = live_q;
        for (int k = 0; k < 2; k++) begin
            live[k] = ledfs_hit(ctrl_q[k], events);
            live_d[k] = live[k];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            live_q <= 2'b00;
        end else begin
            live_q <= live_d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_led
            // Rising edge of the OR restarts the stretch window
            ledfs_stretch #(
                .STRETCH_CYCLES(STRETCH_CYCLES)
            ) u_stretch (
                .i_clk(i_clk),
                .i_nrst(i_nrst),
                .i_enable(ctrl_q[g][`LEDFS_BIT_STRETCH_EN]),
                .i_level(live[g]),
                .i_rise(live[g] && !live_q[g]),
                .o_led(led_out[g])
            );
        end
    endgenerate

    // Stretcher output is a flop; off-stretch it equals the registered OR
    assign o_first_led_output = led_out[0];
    assign o_second_led_output = led_out[1];
endmodule

// >>> core/ledfs_map.svh
// Register offsets, field positions, reset values and timing for the LED select block
`ifndef LEDFS_MAP_SVH
`define LEDFS_MAP_SVH

// ==========================================================================
// Register byte offsets
`define LEDFS_OFF_CTRL_FIRST 12'h000
`define LEDFS_OFF_CTRL_SECOND 12'h004

// ==========================================================================
// Field positions
`define LEDFS_BIT_UNSTRETCHED 15
`define LEDFS_BIT_STRETCH_EN 7
`define LEDFS_BIT_TX_ACT_EN 4
`define LEDFS_BIT_RX_POL_EN 3
`define LEDFS_BIT_RX_ACT_EN 2
`define LEDFS_BIT_JABBER_EN 1
`define LEDFS_BIT_COLL_EN 0
`define LEDFS_WRITABLE_MASK 8'h9f

// ==========================================================================
// Reset values of the writable low byte
`define LEDFS_RST_CTRL_FIRST 8'h88
`define LEDFS_RST_CTRL_SECOND 8'h90

// ==========================================================================
// Stretch timing
`define LEDFS_STRETCH_NS 100000000
`define LEDFS_CLK_PERIOD_NS 10
`define LEDFS_STRETCH_CYCLES (`LEDFS_STRETCH_NS / `LEDFS_CLK_PERIOD_NS)

`endif

// >>> core/ledfs_pkg.sv
// Types shared by the LED select block
package ledfs_pkg;
    typedef logic [4:0] ledfs_event_t;
    typedef logic [7:0] ledfs_ctrl_t;
    typedef enum logic [1:0] {
        LEDFS_IDLE = 2'b01,
        LEDFS_HOLD = 2'b10
    } ledfs_stretch_e;
endpackage

// >>> core/ledfs_stretch.sv
// Pulse stretcher for one LED output
module ledfs_stretch
    import ledfs_pkg::*;
#(
    parameter int STRETCH_CYCLES = 10
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_enable,
    input wire logic i_level,
    input wire logic i_rise,
    output logic o_led
);
    localparam int CW = $clog2(STRETCH_CYCLES + 1);

    ledfs_stretch_e state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic led_q, led_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            LEDFS_IDLE: begin
                if (i_enable && i_rise) begin
                    state_d = LEDFS_HOLD;
                    cnt_d = CW'(STRETCH_CYCLES - 1);
                end
            end
            LEDFS_HOLD: begin
                // Restart on every new rising edge
                if (!i_enable) begin
                    state_d = LEDFS_IDLE;
                end else if (i_rise) begin
                    cnt_d = CW'(STRETCH_CYCLES - 1);
                end else if (cnt_q == '0) begin
                    state_d = LEDFS_IDLE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            default: begin
                state_d = LEDFS_IDLE;
            end
        endcase
        // Stretched view keeps the live level too, so long events stay lit
        led_d = i_level || (i_enable && state_d == LEDFS_HOLD);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_q <= LEDFS_IDLE;
            cnt_q <= '0;
            led_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            led_q <= led_d;
        end
    end

    assign o_led = led_q;
endmodule

// >>> dv/ledfs_properties.sv
// Port checker for the LED select block
module ledfs_properties #(
    parameter int STRETCH_CYCLES = 8
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [11:0] i_paddr,
    input wire logic i_tx_activity,
    input wire logic i_rx_polarity_ok,
    input wire logic i_rx_activity,
    input wire logic i_jabber,
    input wire logic i_collision,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_first_led_output,
    input wire logic o_second_led_output
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====================================
    // Quiet time; saturates so it never wraps
    logic [7:0] idle_q;
    logic [7:0] idle_d;
    always_comb begin
        idle_d = idle_q + {7'h00, idle_q != 8'hff};
        if (i_tx_activity | i_rx_polarity_ok | i_rx_activity | i_jabber | i_collision) begin
            idle_d = 8'h00;
        end
    end
    always_ff @(posedge i_clk) begin
        idle_q <= i_nrst ? idle_d : 8'h00;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // ====================================
    // Assertions
    reset_led_a: assert property (
        $rose(i_nrst) |-> !o_first_led_output && !o_second_led_output)
        else $error("LED lit right after reset");
    quiet_led_a: assert property (
        idle_q > STRETCH_CYCLES + 3 |-> !o_first_led_output && !o_second_led_output)
        else $error("LED lit with no event");
    res_zero_a: assert property (
        o_pready |-> o_prdata[31:16] == 16'h0 && o_prdata[14:8] == 7'h00 && o_prdata[6:5] == 2'h0)
        else $error("reserved read bits not zero");
    ready_after_setup_a: assert property (
        i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    pready_once_a: assert property (
        o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    ready_needs_sel_a: assert property (
        !i_psel |=> !o_pready)
        else $error("ready without request");
    err_addr_a: assert property (
        i_psel && !i_penable && i_paddr > 12'h004 |=> o_pready && o_pslverr)
        else $error("unmapped access not refused");
    err_data_a: assert property (
        o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("error response malformed");
endmodule

bind ledfs_top ledfs_properties #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_ledfs_properties (
    .i_clk, .i_nrst, .i_psel, .i_penable, .i_paddr, .i_tx_activity, .i_rx_polarity_ok,
    .i_rx_activity, .i_jabber, .i_collision, .o_prdata, .o_pready, .o_pslverr,
    .o_first_led_output, .o_second_led_output);

// >>> dv/ledfs_lamps.sv
// Indicator lamp model on the two LED pins
module ledfs_lamps (
    input wire logic i_first,
    input wire logic i_second,
    output logic o_lit_first,
    output logic o_lit_second
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pins are active high: a lamp lights while driven high
    assign o_lit_first = i_first;
    assign o_lit_second = i_second;
endmodule

// >>> dv/ledfs_top_bench.sv
// Self-checking bench for the LED select block
module ledfs_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0, rd, prdata;
    logic [4:0] ev = 5'h00;
    logic pready, pslverr, err, led1, first_led_output, lit1, lit2;
    int failures = 0, n_checks = 0, cyc = 0;
    ledfs_top #(.STRETCH_CYCLES(8)) u_ledfs_top (
        .i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'hf), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_tx_activity(ev[4]),
        .i_rx_polarity_ok(ev[3]), .i_rx_activity(ev[2]), .i_jabber(ev[1]),
        .i_collision(ev[0]), .o_first_led_output(led1), .o_second_led_output(first_led_output));
    ledfs_lamps u_ledfs_lamps (.i_first(led1), .i_second(first_led_output), .o_lit_first(lit1),
        .o_lit_second(lit2));
    // ====================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Waits for pready; only the bench's cycle ceiling ends a hung wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ====================================
    // Clock, hang guard and tests
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h88);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h90);
        // Reserved bits written as zero; bit 15 set to show it is ignored
        apb(1'b1, 12'h000, 32'h809f);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h9f);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 12'h000, 32'h1 << i);
            apb(1'b1, 12'h004, 32'h0);
            ev <= ~(5'h01 << i);
            repeat (3) @(posedge clk);
            chk({lit1, lit2}, 32'h0);
            ev <= 5'h01 << i;
            repeat (3) @(posedge clk);
            chk({lit1, lit2}, 32'h2);
            apb(1'b0, 12'h000, 32'h0);
            chk(rd, 32'h8000 | (32'h1 << i));
            ev <= 5'h00;
            repeat (2) @(posedge clk);
            chk({lit1, lit2}, 32'h0);
        end
        // Second pulse must restart the hold, else it ends too early
        apb(1'b1, 12'h004, 32'h90);
        ev <= 5'h10;
        @(posedge clk);
        ev <= 5'h00;
        repeat (5) @(posedge clk);
        chk(lit2, 32'h1);
        ev <= 5'h10;
        @(posedge clk);
        ev <= 5'h00;
        repeat (7) @(posedge clk);
        chk(lit2, 32'h1);
        repeat (6) @(posedge clk);
        chk(lit2, 32'h0);
        // Two events enabled on the first output; only receive activity is driven
        apb(1'b1, 12'h000, 32'h06);
        ev <= 5'h04;
        repeat (3) @(posedge clk);
        chk({lit1, lit2}, 32'h2);
        ev <= 5'h00;
        // Mid-run reset must bring both defaults back
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h88);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h90);
        apb(1'b0, 12'h008, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        complete_run();
    end
endmodule
